// >>> verilog/emb_mult_top.sv
// Purpose: Multiplier block with its AXI4-Lite configuration and status port.
// Assumes: Fabric drives operands, enable and clear on the clk domain.
// Notes: The product port is live; software sees a per-cycle snapshot.
`timescale 1ns/10ps
`include "emb_regs.svh"

module emb_mult_top
    import emb_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic [`EMB_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [`EMB_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic mulClkEn,
    input wire logic mulAclr,
    input wire emb_opnd_t opnd,
    output emb_prod_t prod
);

    emb_cfg_t cfg_r;
    emb_prod_t liveProd;
    emb_prod_t snap_r;
    logic [`EMB_ADDR_W-1:0] awAddr_r;
    logic awHeld_r;
    logic [31:0] wData_r;
    logic [3:0] wStrb_r;
    logic wHeld_r;
    logic awTake;
    logic wTake;
    logic doWrite;
    logic [`EMB_ADDR_W-1:0] wrAddr;
    logic [31:0] wrData;
    logic [3:0] wrStrb;
    logic [31:0] rdData;
    logic rdHit;

    emb_mult_core uCore (
        .clk(clk),
        .aclr(mulAclr),
        .clkEn(mulClkEn),
        .cfg(cfg_r),
        .opnd(opnd),
        .prod(liveProd)
    );

    assign prod = liveProd;

    // Address and data are taken in either order and held until both exist.
    assign awTake = s_axi_awvalid & s_axi_awready;
    assign wTake = s_axi_wvalid & s_axi_wready;
    assign wrAddr = awHeld_r ? awAddr_r : s_axi_awaddr;
    assign wrData = wHeld_r ? wData_r : s_axi_wdata;
    assign wrStrb = wHeld_r ? wStrb_r : s_axi_wstrb;
    assign doWrite = (awHeld_r | awTake) & (wHeld_r | wTake) & ~s_axi_bvalid;

    always_ff @(posedge clk) begin
        if (reset) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_awready <= ~doWrite & ~(awHeld_r | awTake)
                & ~s_axi_bvalid;
            s_axi_wready <= ~doWrite & ~(wHeld_r | wTake) & ~s_axi_bvalid;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            awHeld_r <= 1'b0;
            awAddr_r <= '0;
        end else if (doWrite) begin
            awHeld_r <= 1'b0;
        end else if (awTake) begin
            awHeld_r <= 1'b1;
            awAddr_r <= s_axi_awaddr;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            wHeld_r <= 1'b0;
            wData_r <= '0;
            wStrb_r <= '0;
        end else if (doWrite) begin
            wHeld_r <= 1'b0;
        end else if (wTake) begin
            wHeld_r <= 1'b1;
            wData_r <= s_axi_wdata;
            wStrb_r <= s_axi_wstrb;
        end
    end

    // The control word steers mode, register bypasses and sign use.
    always_ff @(posedge clk) begin
        if (reset) begin
            cfg_r <= emb_cfg_t'(`EMB_CTRL_RESET);
        end else if (doWrite && wrAddr == `EMB_CTRL_ADDR && wrStrb[0]) begin
            cfg_r <= emb_cfg_t'(wrData[`EMB_CTRL_W-1:0]);
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `EMB_RESP_OKAY;
        end else if (doWrite) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (wrAddr == `EMB_CTRL_ADDR) ? `EMB_RESP_OKAY
                : `EMB_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Snapshot of the live product for software.
    always_ff @(posedge clk) begin
        if (reset) begin
            snap_r <= '0;
        end else begin
            snap_r <= liveProd;
        end
    end

    always_comb begin
        rdData = '0;
        rdHit = 1'b1;
        case (s_axi_araddr)
            `EMB_CTRL_ADDR: begin
                rdData[`EMB_CTRL_W-1:0] = cfg_r;
            end
            `EMB_PRODLO_ADDR: begin
                rdData = snap_r.value[31:0];
            end
            `EMB_PRODHI_ADDR: begin
                rdData[`EMB_PRODHI_W-1:0] =
                    snap_r.value[`EMB_PROD_W-1:`EMB_PROD_W-`EMB_PRODHI_W];
                rdData[`EMB_PRODHI_SIGNED] = snap_r.isSigned;
            end
            `EMB_STATUS_ADDR: begin
                rdData[`EMB_STATUS_W-1:0] = {opnd.signB, opnd.signA,
                    cfg_r.mode};
            end
            default: begin
                rdHit = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            s_axi_arready <= 1'b0;
        end else begin
            s_axi_arready <= ~s_axi_rvalid & ~s_axi_arready;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= `EMB_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rdData;
            s_axi_rresp <= rdHit ? `EMB_RESP_OKAY : `EMB_RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule : emb_mult_top

// >>> inc/emb_regs.svh
// Purpose: Register map, field positions and widths of the multiplier block.
// Assumes: 32-bit AXI4-Lite data, one aligned word per register.
// Notes: Definitions only.
`ifndef EMB_REGS_SVH
`define EMB_REGS_SVH

`define EMB_WIDE_W 18
`define EMB_HALF_W 9
`define EMB_PROD_W 36
`define EMB_SECT_W 18
`define EMB_LANES 2

`define EMB_ADDR_W 5
`define EMB_CTRL_ADDR 5'h00
`define EMB_PRODLO_ADDR 5'h04
`define EMB_PRODHI_ADDR 5'h08
`define EMB_STATUS_ADDR 5'h0C

`define EMB_CTRL_MODE 0
`define EMB_CTRL_REGA 1
`define EMB_CTRL_REGB 2
`define EMB_CTRL_REGSA 3
`define EMB_CTRL_REGSB 4
`define EMB_CTRL_REGOUT 5
`define EMB_CTRL_SIGNUSE 6
`define EMB_CTRL_W 7
`define EMB_CTRL_RESET 7'h00

`define EMB_PRODHI_W 4
`define EMB_PRODHI_SIGNED 8
`define EMB_STATUS_W 3

`define EMB_RESP_OKAY 2'h0
`define EMB_RESP_SLVERR 2'h2

`endif

// >>> inc/emb_pkg.sv
// Purpose: Types shared by the multiplier block files.
// Assumes: emb_regs.svh supplies all widths.
// Notes: Configuration, operand and product carriers.
`include "emb_regs.svh"

package emb_pkg;

    typedef enum logic {
        EMB_MODE_WIDE = 1'b0,
        EMB_MODE_DUAL = 1'b1
    } emb_mode_t;

    typedef struct packed {
        logic signUse;
        logic regOut;
        logic regSignB;
        logic regSignA;
        logic regB;
        logic regA;
        emb_mode_t mode;
    } emb_cfg_t;

    typedef struct packed {
        logic [`EMB_WIDE_W-1:0] dataA;
        logic [`EMB_WIDE_W-1:0] dataB;
        logic signA;
        logic signB;
    } emb_opnd_t;

    typedef struct packed {
        logic [`EMB_PROD_W-1:0] value;
        logic isSigned;
    } emb_prod_t;

endpackage : emb_pkg

// >>> verilog/emb_mult_core.sv
// Purpose: Multiplier stage with optional input, sign and output registers.
// Assumes: Shared clock, clock enable and asynchronous clear.
// Notes: Dual mode packs lane 1 above lane 0 in the product.
`timescale 1ns/10ps
`include "emb_regs.svh"

module emb_mult_core
    import emb_pkg::*;
(
    input wire logic clk,
    input wire logic aclr,
    input wire logic clkEn,
    input wire emb_cfg_t cfg,
    input wire emb_opnd_t opnd,
    output emb_prod_t prod
);

    localparam int W = `EMB_WIDE_W;
    localparam int H = `EMB_HALF_W;
    localparam int S = `EMB_SECT_W;

    logic [W-1:0] aReg_r;
    logic [W-1:0] bReg_r;
    logic saReg_r;
    logic sbReg_r;
    logic sgnReg_r;
    logic [S-1:0] outSec_r [`EMB_LANES];
    logic [W-1:0] aUse;
    logic [W-1:0] bUse;
    logic saUse;
    logic sbUse;
    logic signed [2*W+1:0] wideP;
    logic [S-1:0] laneP [`EMB_LANES];
    logic [`EMB_PROD_W-1:0] rawP;

    always_ff @(posedge clk or posedge aclr) begin
        if (aclr) begin
            aReg_r <= '0;
        end else if (clkEn) begin
            aReg_r <= opnd.dataA;
        end
    end

    always_ff @(posedge clk or posedge aclr) begin
        if (aclr) begin
            bReg_r <= '0;
        end else if (clkEn) begin
            bReg_r <= opnd.dataB;
        end
    end

    always_ff @(posedge clk or posedge aclr) begin
        if (aclr) begin
            saReg_r <= 1'b0;
            sbReg_r <= 1'b0;
        end else if (clkEn) begin
            saReg_r <= opnd.signA;
            sbReg_r <= opnd.signB;
        end
    end

    assign aUse = cfg.regA ? aReg_r : opnd.dataA;
    assign bUse = cfg.regB ? bReg_r : opnd.dataB;
    // Sign inputs are live or registered per regSignA/regSignB; signUse low means unsigned.
    assign saUse = cfg.signUse & (cfg.regSignA ? saReg_r : opnd.signA);
    assign sbUse = cfg.signUse & (cfg.regSignB ? sbReg_r : opnd.signB);

    // One extra bit per operand carries the sign or a zero.
    assign wideP = $signed({saUse & aUse[W-1], aUse})
        * $signed({sbUse & bUse[W-1], bUse});

    genvar g;
    generate
        for (g = 0; g < `EMB_LANES; g++) begin : gLane
            logic [H-1:0] la;
            logic [H-1:0] lb;
            logic signed [2*H+1:0] lp;
            assign la = aUse[g*H +: H];
            assign lb = bUse[g*H +: H];
            // Both lanes follow the single pair of sign controls.
            assign lp = $signed({saUse & la[H-1], la})
                * $signed({sbUse & lb[H-1], lb});
            assign laneP[g] = lp[S-1:0];

            always_ff @(posedge clk or posedge aclr) begin
                if (aclr) begin
                    outSec_r[g] <= '0;
                end else if (clkEn) begin
                    outSec_r[g] <= rawP[g*S +: S];
                end
            end
        end
    endgenerate

    assign rawP = (cfg.mode == EMB_MODE_DUAL) ? {laneP[1], laneP[0]}
        : wideP[`EMB_PROD_W-1:0];

    always_ff @(posedge clk or posedge aclr) begin
        if (aclr) begin
            sgnReg_r <= 1'b0;
        end else if (clkEn) begin
            sgnReg_r <= saUse | sbUse;
        end
    end

    assign prod.value = cfg.regOut ? {outSec_r[1], outSec_r[0]} : rawP;
    assign prod.isSigned = cfg.regOut ? sgnReg_r : (saUse | sbUse);

endmodule : emb_mult_core

// >>> bench/emb_fabric_model.sv
// Purpose: Fabric logic that drives the multiplier operands.
// Assumes: Requests change right after a rising clock edge.
// Notes: Outputs hold until the next request.
`timescale 1ns/10ps

module emb_fabric_model
    import emb_pkg::*;
(
    input wire logic clk,
    output emb_opnd_t opnd,
    output logic mulClkEn,
    output logic mulAclr
);
    initial begin
        opnd = '0;
        mulClkEn = 1'h1;
        mulAclr = 1'h0;
    end

    task automatic put(input logic [17:0] a, input logic [17:0] b,
        input logic sa, input logic sb, input logic en, input logic clr);
        @(posedge clk);
        opnd <= {a, b, sa, sb};
        mulClkEn <= en;
        mulAclr <= clr;
    endtask : put
endmodule : emb_fabric_model

// >>> bench/emb_mult_sva.sv
// Purpose: Checks the product port against the control word in use.
// Assumes: Control word is mirrored from completed bus writes.
// Notes: Checks other than chk_clr_zero pause while a write response is pending.
`timescale 1ns/10ps
`include "emb_regs.svh"

module emb_mult_sva
    import emb_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic [`EMB_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic mulClkEn,
    input wire logic mulAclr,
    input wire emb_opnd_t opnd,
    input wire emb_prod_t prod
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);

    logic [4:0] awAddr_r;
    logic [6:0] wByte_r;
    logic wEn_r;
    logic [6:0] cfg_r;
    logic sA;
    logic sB;
    logic g;
    logic [35:0] expW;
    logic [35:0] expD;

    function automatic logic [35:0] mw(input logic [17:0] a,
        input logic [17:0] b, input logic sa, input logic sb);
        logic signed [36:0] p;
        p = $signed({sa & a[17], a}) * $signed({sb & b[17], b});
        return p[35:0];
    endfunction : mw

    function automatic logic [17:0] mn(input logic [8:0] a,
        input logic [8:0] b, input logic sa, input logic sb);
        logic signed [18:0] p;
        p = $signed({sa & a[8], a}) * $signed({sb & b[8], b});
        return p[17:0];
    endfunction : mn

    always_ff @(posedge clk) begin
        if (s_axi_awvalid && s_axi_awready) begin
            awAddr_r <= s_axi_awaddr;
        end
    end

    always_ff @(posedge clk) begin
        if (s_axi_wvalid && s_axi_wready) begin
            wByte_r <= s_axi_wdata[6:0];
            wEn_r <= s_axi_wstrb[0];
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            cfg_r <= 7'h00;
        end else if (s_axi_bvalid && s_axi_bresp == `EMB_RESP_OKAY &&
            awAddr_r == `EMB_CTRL_ADDR && wEn_r) begin
            cfg_r <= wByte_r;
        end
    end

    assign sA = cfg_r[6] & opnd.signA;
    assign sB = cfg_r[6] & opnd.signB;
    assign g = !s_axi_bvalid;
    assign expW = mw(opnd.dataA, opnd.dataB, sA, sB);
    assign expD = {mn(opnd.dataA[17:9], opnd.dataB[17:9], sA, sB),
        mn(opnd.dataA[8:0], opnd.dataB[8:0], sA, sB)};

    chk_wide_unsg: assert property (g && cfg_r == 7'h00 |->
        prod.value == expW && !prod.isSigned) else $error("unsigned product");
    chk_wide_sign: assert property (g && cfg_r == 7'h40 |->
        prod.value == expW) else $error("signed product wrong");
    chk_sign_flag: assert property (g && cfg_r == 7'h40 |->
        prod.isSigned == (opnd.signA | opnd.signB)) else $error("sign flag");
    chk_dual_lanes: assert property (g && cfg_r == 7'h41 |->
        prod.value == expD) else $error("dual lanes wrong");
    chk_in_only: assert property (g && cfg_r == 7'h02 && mulClkEn &&
        !mulAclr |=> s_axi_bvalid || mulAclr || prod.value ==
        {18'h0, $past(opnd.dataA)} * {18'h0, opnd.dataB})
        else $error("registered A path wrong");
    chk_two_stage: assert property ((g && cfg_r == 7'h7E && mulClkEn &&
        !mulAclr) ##1 (mulClkEn && !mulAclr) |=> s_axi_bvalid || mulAclr ||
        prod.value == $past(expW, 2)) else $error("registered path wrong");
    chk_hold_off: assert property (g && cfg_r == 7'h7E && !mulClkEn &&
        !mulAclr |=> mulAclr || $stable(prod)) else $error("hold failed");
    chk_clr_zero: assert property (cfg_r == 7'h7E && mulAclr |->
        prod == '0) else $error("clear failed");
endmodule : emb_mult_sva

// >>> bench/emb_mult_block_bench.sv
// Purpose: Self-checking bench for the multiplier block.
// Assumes: Bus requests start right after a rising clock edge.
// Notes: Expected products are worked out by hand.
`timescale 1ns/10ps
`include "emb_regs.svh"

module embedded_multiplier_block_bench
    import emb_pkg::*;
;
    logic clk, reset, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
    logic s_axi_arready, s_axi_rvalid, s_axi_rready, mulClkEn, mulAclr;
    logic [4:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    emb_opnd_t opnd;
    emb_prod_t prod;
    int checked, fail_count;
    logic [35:0] wideExp [4] = '{36'hFFFF40002, 36'hFFFF80002,
        36'hFFFFC0002, 36'h000000002};
    logic [35:0] dualExp [4] = '{{18'h3FA02, 18'h005FD},
        {18'h3FC02, 18'h3FFFD}, {18'h3FE02, 18'h005FD},
        {18'h00002, 18'h3FFFD}};
    logic [1:0] k;

    emb_mult_top dut_u (.clk, .reset, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .mulClkEn, .mulAclr,
        .opnd, .prod);
    emb_fabric_model fab_u (.clk, .opnd, .mulClkEn, .mulAclr);

    initial begin
        clk = 1'h0;
        forever #2 clk = ~clk;
    end

    task automatic check(input logic [36:0] got, input logic [36:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : check

    task automatic summarize();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : summarize

    task automatic axiWr(input logic [4:0] a, input logic [31:0] d,
        input logic [3:0] s, input logic [1:0] r);
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        // Each half drops at the edge that takes it; loop until both taken.
        do begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while ((s_axi_awvalid && !s_axi_awready)
            || (s_axi_wvalid && !s_axi_wready));
        while (s_axi_bvalid !== 1'h1) @(posedge clk);
        s_axi_bready <= 1'h0;
        check(s_axi_bresp, r);
    endtask : axiWr

    task automatic axiRd(input logic [4:0] a, input logic [31:0] d,
        input logic [1:0] r);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do @(posedge clk); while (s_axi_arready !== 1'h1);
        s_axi_arvalid <= 1'h0;
        while (s_axi_rvalid !== 1'h1) @(posedge clk);
        s_axi_rready <= 1'h0;
        check(s_axi_rdata, d);
        check(s_axi_rresp, r);
    endtask : axiRd

    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
        {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
        {s_axi_wdata, s_axi_wstrb} = '0;
        reset = 1'h1;
        repeat (5) @(posedge clk);
        reset <= 1'h0;
        axiRd(`EMB_CTRL_ADDR, 32'h0, `EMB_RESP_OKAY);
        axiRd(5'h10, 32'h0, `EMB_RESP_SLVERR);
        axiWr(`EMB_PRODLO_ADDR, 32'h1, 4'hF, `EMB_RESP_SLVERR);
        for (int c = 0; c < 2; c++) begin
            axiWr(`EMB_CTRL_ADDR, c ? 32'h40 : 32'h0, 4'hF, `EMB_RESP_OKAY);
            for (int s = 0; s < 4; s++) begin
                fab_u.put(18'h3FFFF, 18'h3FFFE, s[1], s[0], 1'h1, 1'h0);
                #1;
                k = c ? s[1:0] : 2'h0;
                check(prod.value, wideExp[k]);
                check(prod.isSigned, k != 2'h0);
            end
        end
        axiWr(`EMB_CTRL_ADDR, 32'h41, 4'hF, `EMB_RESP_OKAY);
        for (int s = 0; s < 4; s++) begin
            fab_u.put(18'h3FE03, 18'h3FDFF, s[1], s[0], 1'h1, 1'h0);
            #1;
            check(prod.value, dualExp[s]);
        end
        axiWr(`EMB_CTRL_ADDR, 32'h0, 4'h0, `EMB_RESP_OKAY);
        axiRd(`EMB_CTRL_ADDR, 32'h41, `EMB_RESP_OKAY);
        axiRd(`EMB_PRODLO_ADDR, 32'hBFFFD, `EMB_RESP_OKAY);
        axiRd(`EMB_PRODHI_ADDR, 32'h100, `EMB_RESP_OKAY);
        axiRd(`EMB_STATUS_ADDR, 32'h7, `EMB_RESP_OKAY);
        axiWr(`EMB_CTRL_ADDR, 32'h02, 4'hF, `EMB_RESP_OKAY);
        fab_u.put(18'h3, 18'h5, 1'h0, 1'h0, 1'h1, 1'h0);
        fab_u.put(18'h7, 18'hB, 1'h0, 1'h0, 1'h1, 1'h0);
        #1;
        check(prod.value, 36'h21);
        axiWr(`EMB_CTRL_ADDR, 32'h7E, 4'hF, `EMB_RESP_OKAY);
        fab_u.put(18'h3FFFF, 18'h3FFFE, 1'h1, 1'h0, 1'h1, 1'h0);
        fab_u.put(18'h5, 18'h5, 1'h0, 1'h0, 1'h1, 1'h0);
        fab_u.put(18'h5, 18'h5, 1'h0, 1'h0, 1'h0, 1'h0);
        #1;
        check(prod, {36'hFFFFC0002, 1'h1});
        repeat (2) @(posedge clk);
        #1;
        check(prod, {36'hFFFFC0002, 1'h1});
        fab_u.put(18'h5, 18'h5, 1'h0, 1'h0, 1'h0, 1'h1);
        #1;
        check(prod, '0);
        fab_u.put(18'h5, 18'h5, 1'h0, 1'h0, 1'h1, 1'h0);
        summarize();
    end

    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        summarize();
    end
endmodule : embedded_multiplier_block_bench

bind emb_mult_top emb_mult_sva chk_u (.clk, .reset, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .mulClkEn,
    .mulAclr, .opnd, .prod);
